/* File: prfc_map.vh */
// Constants of the PHY receive frame control block.
// Assumes a single 250 MHz interface clock; times are in ns.
`ifndef PRFC_MAP_VH
`define PRFC_MAP_VH
`define PRFC_CLK_MHZ 250
`define PRFC_RX_DELAY_NS 1000
`define PRFC_SYNC_DELAY_NS 200
`define PRFC_ACT_DROP_NS 200
`define PRFC_MIN_INTERFRAME_SPACING_NS 1875
`define PRFC_FLUSH_NS 100
// Least times round up, MIN_INTERFRAME_SPACING rounds down, 468.75 cycles to 468
`define PRFC_RX_DELAY_CYC ((`PRFC_RX_DELAY_NS*`PRFC_CLK_MHZ+999)/1000)
`define PRFC_SYNC_DELAY_CYC ((`PRFC_SYNC_DELAY_NS*`PRFC_CLK_MHZ+999)/1000)
`define PRFC_ACT_DROP_CYC ((`PRFC_ACT_DROP_NS*`PRFC_CLK_MHZ+999)/1000)
`define PRFC_MIN_INTERFRAME_SPACING_CYC ((`PRFC_MIN_INTERFRAME_SPACING_NS*`PRFC_CLK_MHZ)/1000)
`define PRFC_FLUSH_CYC ((`PRFC_FLUSH_NS*`PRFC_CLK_MHZ+999)/1000)
// Header layout, octet indices
`define PRFC_HDR_LEN 18
`define PRFC_HDR_LEN_LO 0
`define PRFC_HDR_LEN_HI 1
`define PRFC_HDR_FLAGS 2
`define PRFC_FLAG_BURST 0
`define PRFC_FLAG_PT 1
`define PRFC_LEN_HI_BITS 6
// Error octet bits
`define PRFC_ERR_HCS 0
// Checksum
`define PRFC_HCS_INIT 16'hffff
`define PRFC_HCS_POLY 16'h1021
// Interface configuration bit for double data rate
`define PRFC_CFG_DDR 1
// Tail octet indices
`define PRFC_TAIL_SIGNAL_STRENGTH_OCTET 2'h0
`define PRFC_TAIL_LQI 2'h1
`define PRFC_TAIL_ERR 2'h2
`define PRFC_FCS_LEN 4
`endif

/* File: prfc_fifo2.v */
// Small FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module prfc_fifo2 #(
  parameter WIDTH = 9,
  parameter DEPTH = 2,
  parameter AW = 1
) (
  input wire i_clock,
  input wire i_resetn,
  input wire i_in_valid,
  output wire o_in_ready,
  input wire [WIDTH-1:0] i_in_data,
  output wire o_out_valid,
  input wire i_out_ready,
  output wire [WIDTH-1:0] o_out_data
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop;
  assign o_in_ready = (cnt_q != DEPTH[AW:0]);
  assign o_out_valid = (cnt_q != {(AW+1){1'b0}});
  assign o_out_data = mem_q[rd_q];
  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;

  always @(posedge i_clock) begin
    if (push) begin
      mem_q[wr_q] <= i_in_data;
    end
  end

  always @(posedge i_clock) begin
    if (!i_resetn) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule // prfc_fifo2

/* File: prfc_rx.v */
// PHY-side receive frame control: acquisition, header check, octet stream.
// Assumes a demodulator feeding octets with valid/ready and frame markers.
`timescale 1ns/1ps
`include "prfc_map.vh"
module prfc_rx #(
  parameter RX_DELAY_CYC = `PRFC_RX_DELAY_CYC,
  parameter SYNC_DELAY_CYC = `PRFC_SYNC_DELAY_CYC,
  parameter ACT_DROP_CYC = `PRFC_ACT_DROP_CYC,
  parameter MIN_INTERFRAME_SPACING_CYC = `PRFC_MIN_INTERFRAME_SPACING_CYC,
  parameter FLUSH_CYC = `PRFC_FLUSH_CYC,
  parameter RNG_PREC_LSB = 0,
  parameter RNG_SUPPORTED = 1,
  parameter FIFO_DEPTH = 2
) (
  input wire i_clock,
  input wire i_resetn,
  input wire i_rx_en,
  input wire i_tx_en,
  input wire i_preamble_type_select,
  input wire i_preamble_follow_bit,
  input wire i_ranging_enable_bit,
  input wire [7:0] i_interface_config_register,
  input wire [1:0] i_receive_antenna_select,
  input wire [7:0] i_receive_channel_select,
  input wire i_out_hold,
  input wire i_sync_found,
  input wire i_rng_ref,
  input wire i_sym_valid,
  input wire [7:0] i_sym_data,
  input wire i_sym_last,
  input wire [7:0] i_signal_strength_octet,
  input wire [7:0] i_link_quality_octet,
  output wire o_sym_ready,
  output wire o_acq_enable,
  output wire o_acq_burst_preamble,
  output wire [1:0] o_acq_antenna,
  output wire [7:0] o_acq_channel,
  output wire o_rx_path_on,
  output wire o_tx_path_en,
  output wire o_activity_flag,
  output wire o_data_oe,
  output reg [7:0] o_data_rise,
  output reg [7:0] o_data_fall,
  output reg o_data_valid,
  output reg o_fall_valid,
  output reg [31:0] o_ranging_timestamp_register
);
  localparam S_IDLE = 4'h0;
  localparam S_TURNON = 4'h1;
  localparam S_SEARCH = 4'h2;
  localparam S_SYNC = 4'h3;
  localparam S_HDR = 4'h4;
  localparam S_HERR = 4'h5;
  localparam S_PAY = 4'h6;
  localparam S_FCS = 4'h7;
  localparam S_TAIL = 4'h8;
  localparam S_WAIT = 4'h9;
  localparam S_DONE = 4'ha;
  localparam S_TX = 4'hb;
  localparam S_FLUSH = 4'hc;

  reg [3:0] st_q;
  reg [15:0] cnt_q;
  reg [15:0] drop_q;
  reg [15:0] min_interframe_spacing_q;
  reg act_q;
  reg drop_run_q;
  reg rx_en_q;
  reg pt_q;
  reg pt_hdr_q;
  reg burst_q;
  reg herr_q;
  reg [13:0] len_q;
  reg [15:0] hcs_q;
  reg [15:0] hcs_rx_q;
  reg [31:0] timer_q;
  reg [7:0] rise_q;
  reg half_q;
  reg [8:0] push_data;
  reg push_valid;
  reg fwd;
  wire push_ready;
  wire pop_valid;
  wire [8:0] pop_data;
  wire pop;
  wire ddr;
  wire sym_take;
  wire in_rx;

  function [15:0] hcs_step;
    input [15:0] c;
    input [7:0] d;
    integer k;
    reg [15:0] r;
    begin
      r = c ^ {d, 8'h00};
      for (k = 0; k < 8; k = k + 1) begin
        r = r[15] ? ((r << 1) ^ `PRFC_HCS_POLY) : (r << 1);
      end
      hcs_step = r;
    end
  endfunction

  assign ddr = i_interface_config_register[`PRFC_CFG_DDR];
  assign in_rx = (st_q != S_IDLE) && (st_q != S_TX) && (st_q != S_FLUSH);
  assign o_data_oe = in_rx;
  assign o_rx_path_on = in_rx;
  assign o_acq_enable = (st_q == S_SEARCH);
  assign o_acq_burst_preamble = (pt_hdr_q & i_preamble_follow_bit) ? pt_q :
    i_preamble_type_select;
  assign o_acq_antenna = i_receive_antenna_select;
  assign o_acq_channel = i_receive_channel_select;
  assign o_activity_flag = act_q;
  // Cut without a clock edge of delay when transmit enable falls
  assign o_tx_path_en = (st_q == S_TX) & i_tx_en;
  // Discarded octets are always taken so the demodulator never wedges
  // Held off while the error octet goes in, so no payload octet is lost
  assign o_sym_ready = fwd ? push_ready : (st_q != S_HERR);
  assign sym_take = i_sym_valid & o_sym_ready;

  always @* begin
    fwd = (st_q == S_HDR) || (st_q == S_PAY) || (st_q == S_FCS);
    push_valid = 1'b0;
    push_data = {1'b0, i_sym_data};
    if (fwd) begin
      push_valid = i_sym_valid;
    end else if (st_q == S_HERR) begin
      push_valid = 1'b1;
      push_data = {1'b0, 7'h00, herr_q};
    end else if (st_q == S_TAIL) begin
      push_valid = 1'b1;
      case (cnt_q[1:0])
        `PRFC_TAIL_SIGNAL_STRENGTH_OCTET: push_data = {1'b0, i_signal_strength_octet};
        `PRFC_TAIL_LQI: push_data = {1'b0, i_link_quality_octet};
        default: push_data = {1'b1, 7'h00, herr_q};
      endcase
    end
  end

  prfc_fifo2 #(
    .WIDTH(9),
    .DEPTH(FIFO_DEPTH),
    .AW(1)
  ) u_buf (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .i_in_valid(push_valid),
    .o_in_ready(push_ready),
    .i_in_data(push_data),
    .o_out_valid(pop_valid),
    .i_out_ready(~i_out_hold),
    .o_out_data(pop_data)
  );
  assign pop = pop_valid & ~i_out_hold;

  // Output stage; double-rate pairs two octets, a lone last octet rises alone
  always @(posedge i_clock) begin
    if (!i_resetn || !in_rx) begin
      o_data_rise <= 8'h00;
      o_data_fall <= 8'h00;
      o_data_valid <= 1'b0;
      o_fall_valid <= 1'b0;
      rise_q <= 8'h00;
      half_q <= 1'b0;
    end else begin
      o_data_valid <= 1'b0;
      o_fall_valid <= 1'b0;
      if (pop) begin
        if (!ddr) begin
          o_data_rise <= pop_data[7:0];
          o_data_valid <= 1'b1;
        end else if (!half_q && pop_data[8]) begin
          o_data_rise <= pop_data[7:0];
          o_data_valid <= 1'b1;
        end else if (!half_q) begin
          rise_q <= pop_data[7:0];
          half_q <= 1'b1;
        end else begin
          o_data_rise <= rise_q;
          o_data_fall <= pop_data[7:0];
          o_data_valid <= 1'b1;
          o_fall_valid <= 1'b1;
          half_q <= 1'b0;
        end
      end
    end
  end

  // Ranging timer latch
  always @(posedge i_clock) begin
    if (!i_resetn) begin
      timer_q <= 32'h0000_0000;
      o_ranging_timestamp_register <= 32'h0000_0000;
    end else begin
      timer_q <= timer_q + 32'h0000_0001;
      if (i_rng_ref && i_ranging_enable_bit && RNG_SUPPORTED != 0 && act_q) begin
        o_ranging_timestamp_register <= (timer_q >> RNG_PREC_LSB)
          << RNG_PREC_LSB;
      end
    end
  end

  // Activity drop and MIN_INTERFRAME_SPACING timing run from the packet trailing edge
  always @(posedge i_clock) begin
    if (!i_resetn || !in_rx) begin
      drop_q <= 16'h0000;
      drop_run_q <= 1'b0;
      min_interframe_spacing_q <= 16'h0000;
    end else begin
      if (i_sym_last && act_q) begin
        drop_q <= ACT_DROP_CYC[15:0];
        drop_run_q <= 1'b1;
        min_interframe_spacing_q <= MIN_INTERFRAME_SPACING_CYC[15:0];
      end else begin
        if (drop_q != 16'h0000) begin
          drop_q <= drop_q - 16'h0001;
        end
        if (drop_q == 16'h0001) begin
          drop_run_q <= 1'b0;
        end
        if (min_interframe_spacing_q != 16'h0000) begin
          min_interframe_spacing_q <= min_interframe_spacing_q - 16'h0001;
        end
      end
    end
  end

  always @(posedge i_clock) begin
    if (!i_resetn) begin
      st_q <= S_IDLE;
      cnt_q <= 16'h0000;
      act_q <= 1'b0;
      rx_en_q <= 1'b0;
      pt_q <= 1'b0;
      pt_hdr_q <= 1'b0;
      burst_q <= 1'b0;
      herr_q <= 1'b0;
      len_q <= 14'h0000;
      hcs_q <= `PRFC_HCS_INIT;
      hcs_rx_q <= 16'h0000;
    end else begin
      rx_en_q <= i_rx_en;
      if (in_rx && !i_rx_en) begin
        st_q <= S_IDLE;
        act_q <= 1'b0;
        pt_hdr_q <= 1'b0;
      end else begin
        // Falls on its own count even while the tail is still stalled
        if (act_q && drop_run_q && drop_q == 16'h0001) begin
          act_q <= 1'b0;
        end
        case (st_q)
          S_IDLE: begin
            if (i_rx_en && !rx_en_q && !i_tx_en) begin
              st_q <= S_TURNON;
              cnt_q <= RX_DELAY_CYC[15:0];
              pt_hdr_q <= 1'b0;
            end else if (i_tx_en) begin
              st_q <= S_TX;
              act_q <= 1'b1;
            end
          end
          S_TURNON: begin
            if (cnt_q <= 16'h0001) begin
              st_q <= S_SEARCH;
            end
            cnt_q <= cnt_q - 16'h0001;
          end
          S_SEARCH: begin
            if (i_sync_found) begin
              st_q <= S_SYNC;
              cnt_q <= SYNC_DELAY_CYC[15:0];
            end
          end
          S_SYNC: begin
            if (cnt_q <= 16'h0001) begin
              act_q <= 1'b1;
              st_q <= S_HDR;
              cnt_q <= 16'h0000;
              hcs_q <= `PRFC_HCS_INIT;
            end else begin
              cnt_q <= cnt_q - 16'h0001;
            end
          end
          S_HDR: begin
            if (sym_take) begin
              cnt_q <= cnt_q + 16'h0001;
              if (cnt_q < `PRFC_HDR_LEN - 2) begin
                hcs_q <= hcs_step(hcs_q, i_sym_data);
              end else begin
                hcs_rx_q <= {hcs_rx_q[7:0], i_sym_data};
              end
              if (cnt_q == `PRFC_HDR_LEN_LO) begin
                len_q[7:0] <= i_sym_data;
              end
              if (cnt_q == `PRFC_HDR_LEN_HI) begin
                len_q[13:8] <= i_sym_data[`PRFC_LEN_HI_BITS-1:0];
              end
              if (cnt_q == `PRFC_HDR_FLAGS) begin
                burst_q <= i_sym_data[`PRFC_FLAG_BURST];
                pt_q <= i_sym_data[`PRFC_FLAG_PT];
              end
              if (cnt_q == `PRFC_HDR_LEN - 1) begin
                st_q <= S_HERR;
                herr_q <= ({hcs_rx_q[7:0], i_sym_data} != hcs_q);
              end
            end
          end
          S_HERR: begin
            if (push_ready) begin
              cnt_q <= 16'h0000;
              // Failed header is treated as a zero-length frame
              if (herr_q || len_q == 14'h0000) begin
                st_q <= S_TAIL;
              end else begin
                st_q <= S_PAY;
              end
            end
          end
          S_PAY: begin
            if (sym_take) begin
              cnt_q <= cnt_q + 16'h0001;
              if (cnt_q == {2'b00, len_q} - 16'h0001) begin
                st_q <= S_FCS;
                cnt_q <= 16'h0000;
              end
            end
          end
          S_FCS: begin
            if (sym_take) begin
              cnt_q <= cnt_q + 16'h0001;
              if (cnt_q == `PRFC_FCS_LEN - 1) begin
                st_q <= S_TAIL;
                cnt_q <= 16'h0000;
              end
            end
          end
          S_TAIL: begin
            if (push_ready) begin
              cnt_q <= cnt_q + 16'h0001;
              if (cnt_q[1:0] == `PRFC_TAIL_ERR) begin
                st_q <= S_WAIT;
              end
            end
          end
          S_WAIT: begin
            if (!act_q && herr_q) begin
              // Untrusted header: its burst flag is ignored; in a followed burst its type flag still sets the type, else same type again
              st_q <= S_SEARCH;
            end else if (!act_q && min_interframe_spacing_q <= 16'h0001 && burst_q) begin
              st_q <= S_SEARCH;
              pt_hdr_q <= i_preamble_follow_bit;
            end else if (!act_q && !burst_q) begin
              st_q <= S_DONE;
            end
          end
          S_DONE: begin
            st_q <= S_DONE;
          end
          S_TX: begin
            if (!i_tx_en) begin
              st_q <= S_FLUSH;
              cnt_q <= FLUSH_CYC[15:0];
            end
          end
          S_FLUSH: begin
            if (cnt_q <= 16'h0001) begin
              act_q <= 1'b0;
              st_q <= S_IDLE;
            end
            cnt_q <= cnt_q - 16'h0001;
          end
          default: st_q <= S_IDLE;
        endcase
      end
    end
  end
endmodule // prfc_rx

/* File: prfc_mac_model.sv */
// MAC-side octet sink for prfc_rx: captures qualified octets, stalls.
// Assumes the block's one clock; stall pattern changes on falling edges.
`timescale 1ns/1ps
module prfc_mac_model (
  input wire i_clock,
  input wire i_resetn,
  input wire i_data_valid,
  input wire i_fall_valid,
  input wire [7:0] i_data_rise,
  input wire [7:0] i_data_fall,
  input wire i_stall_en,
  output reg o_out_hold
);
  reg [2:0] cnt_q = 3'h0;
  logic [7:0] got[$];
  integer falls = 0;
  initial o_out_hold = 1'b0;
  always @(posedge i_clock) begin
    if (i_resetn && i_data_valid) begin
      got.push_back(i_data_rise);
      if (i_fall_valid) begin
        got.push_back(i_data_fall);
        falls = falls + 1;
      end
    end
  end
  // Two-on two-off stall keeps the two-entry buffer filling and draining
  always @(negedge i_clock) begin
    cnt_q <= cnt_q + 3'h1;
    o_out_hold <= i_stall_en & cnt_q[1];
  end
endmodule // prfc_mac_model

/* File: prfc_rx_sva.sv */
// Port-level checker for prfc_rx.
// Assumes one clock and a synchronous active-low reset; bound below.
`timescale 1ns/1ps
module prfc_rx_sva #(
  parameter RX_DELAY_CYC = 2,
  parameter SYNC_DELAY_CYC = 2,
  parameter FLUSH_CYC = 2
) (
  input wire i_clock,
  input wire i_resetn,
  input wire i_rx_en,
  input wire i_tx_en,
  input wire i_preamble_type_select,
  input wire i_preamble_follow_bit,
  input wire i_ranging_enable_bit,
  input wire [7:0] i_interface_config_register,
  input wire i_sync_found,
  input wire o_acq_enable,
  input wire o_acq_burst_preamble,
  input wire o_tx_path_en,
  input wire o_activity_flag,
  input wire o_data_oe,
  input wire o_data_valid,
  input wire o_fall_valid,
  input wire [31:0] o_ranging_timestamp_register
);
  localparam int RXD = RX_DELAY_CYC;
  localparam int SYP = SYNC_DELAY_CYC + 1;
  localparam int FLP = FLUSH_CYC + 2;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  chk_rx_entry_cause: assert property ($rose(o_data_oe) |->
    $past(i_rx_en) && !$past(i_tx_en)) else $error("oe rose unasked");
  chk_turn_on_delay: assert property ($rose(o_data_oe) |->
    !o_acq_enable ##RXD (o_acq_enable || !i_rx_en))
    else $error("search start off time");
  chk_sync_to_active: assert property ((o_acq_enable && i_sync_found) |->
    ##SYP (o_activity_flag || !i_rx_en)) else $error("activity late");
  chk_rx_release: assert property (!i_rx_en |=> !o_data_oe)
    else $error("bus kept after enable drop");
  chk_tx_cut_now: assert property (!i_tx_en |-> !o_tx_path_en)
    else $error("tx path on without enable");
  chk_tx_flush_end: assert property ($fell(o_tx_path_en) |->
    ##[1:FLP] !o_activity_flag) else $error("flush too long");
  chk_ddr_only: assert property (o_fall_valid |-> o_data_valid &&
    i_interface_config_register[1]) else $error("fall octet in sdr");
  chk_valid_in_rx: assert property (o_data_valid |-> o_data_oe)
    else $error("octet outside receive");
  chk_ranging_off: assert property (!i_ranging_enable_bit |=>
    $stable(o_ranging_timestamp_register)) else $error("timer moved");
  chk_preamble_reg: assert property (!i_preamble_follow_bit |->
    o_acq_burst_preamble == i_preamble_type_select)
    else $error("preamble type wrong");
endmodule // prfc_rx_sva
bind prfc_rx prfc_rx_sva #(.RX_DELAY_CYC(RX_DELAY_CYC),
  .SYNC_DELAY_CYC(SYNC_DELAY_CYC), .FLUSH_CYC(FLUSH_CYC)) u_sva (
  .i_clock, .i_resetn, .i_rx_en, .i_tx_en, .i_preamble_type_select,
  .i_preamble_follow_bit, .i_ranging_enable_bit,
  .i_interface_config_register, .i_sync_found, .o_acq_enable,
  .o_acq_burst_preamble, .o_tx_path_en, .o_activity_flag, .o_data_oe,
  .o_data_valid, .o_fall_valid, .o_ranging_timestamp_register);

/* File: prfc_rx_tb_top.sv */
// Testbench for prfc_rx: frames, header error, burst, double rate, tx abort.
// Assumes prfc_mac_model as octet sink and prfc_rx_sva bound to the block.
`timescale 1ns/1ps
`include "prfc_map.vh"
module prfc_rx_tb_top;
  localparam RXD = 4;
  localparam SYD = 3;
  localparam MIF = 20;
  localparam FLU = 3;
  localparam SIGNAL_STRENGTH_OCTET = 8'h5a;
  localparam LINK_QUALITY_OCTET = 8'hc3;
  // MAC's own frame check polynomial
  localparam [31:0] FCS_POLY = 32'h04c1_1db7;
  reg i_clock = 1'b0;
  reg i_resetn = 1'b0;
  reg i_rx_en = 1'b0;
  reg i_tx_en = 1'b0;
  reg i_preamble_type_select = 1'b0;
  reg i_preamble_follow_bit = 1'b0;
  reg i_ranging_enable_bit = 1'b0;
  reg [7:0] i_interface_config_register = 8'h00;
  reg i_sync_found = 1'b0;
  reg i_rng_ref = 1'b0;
  reg i_sym_valid = 1'b0;
  reg [7:0] i_sym_data = 8'h00;
  reg i_sym_last = 1'b0;
  reg stall = 1'b0;
  wire i_out_hold, o_sym_ready, o_acq_enable, o_acq_burst_preamble;
  wire o_tx_path_en, o_activity_flag, o_data_oe, o_data_valid, o_fall_valid;
  wire [7:0] o_data_rise, o_data_fall;
  wire [31:0] o_ranging_timestamp_register;
  wire o_rx_path_on;
  wire [1:0] o_acq_antenna;
  wire [7:0] o_acq_channel;
  integer num_errors = 0;
  integer checked = 0;
  integer waited;
  integer t_last;
  integer t_rng;
  integer tr0;
  reg [31:0] ts0;
  logic [7:0] exp_q[$];
  prfc_rx #(.RX_DELAY_CYC(RXD), .SYNC_DELAY_CYC(SYD), .ACT_DROP_CYC(3),
    .MIN_INTERFRAME_SPACING_CYC(MIF), .FLUSH_CYC(FLU)) DUT (
    .i_clock, .i_resetn, .i_rx_en, .i_tx_en, .i_preamble_type_select,
    .i_preamble_follow_bit, .i_ranging_enable_bit,
    .i_interface_config_register, .i_receive_antenna_select(2'h1),
    .i_receive_channel_select(8'h09), .i_out_hold, .i_sync_found, .i_rng_ref,
    .i_sym_valid, .i_sym_data, .i_sym_last,
    .i_signal_strength_octet(SIGNAL_STRENGTH_OCTET), .i_link_quality_octet(LINK_QUALITY_OCTET),
    .o_sym_ready, .o_acq_enable, .o_acq_burst_preamble, .o_acq_antenna,
    .o_acq_channel, .o_rx_path_on, .o_tx_path_en, .o_activity_flag,
    .o_data_oe, .o_data_rise, .o_data_fall, .o_data_valid, .o_fall_valid,
    .o_ranging_timestamp_register);
  prfc_mac_model mac (.i_clock, .i_resetn, .i_data_valid(o_data_valid),
    .i_fall_valid(o_fall_valid), .i_data_rise(o_data_rise),
    .i_data_fall(o_data_fall), .i_stall_en(stall), .o_out_hold(i_out_hold));
  always #2 i_clock = ~i_clock;
  task finish_test;
    if (num_errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task check(input [31:0] seen, input [31:0] want);
    checked = checked + 1;
    if (seen !== want) begin
      num_errors = num_errors + 1;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask
  function [15:0] crc16(input [15:0] c, input [7:0] d);
    integer b;
    for (b = 7; b >= 0; b = b - 1)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[b]) ? `PRFC_HCS_POLY : 16'h0000);
    crc16 = c;
  endfunction
  function [31:0] fcs32(input [31:0] c, input [7:0] d);
    integer b;
    for (b = 7; b >= 0; b = b - 1)
      c = {c[30:0], 1'b0} ^ ((c[31] ^ d[b]) ? FCS_POLY : 32'h0000_0000);
    fcs32 = c;
  endfunction
  // Kinds: 0 search on, 1 activity up, 2 activity down, 3 sink caught up
  task wait_on(input integer k);
    reg c;
    begin
      c = 1'b0;
      waited = 0;
      while (!c && waited < 400) begin
        @(negedge i_clock);
        waited = waited + 1;
        case (k)
          0: c = (o_acq_enable === 1'b1);
          1: c = (o_activity_flag === 1'b1);
          2: c = (o_activity_flag === 1'b0);
          default: c = (mac.got.size() == exp_q.size());
        endcase
      end
      if (!c) check(k, 32'hffff);
    end
  endtask
  // Request and data held until the edge that sees ready
  task send_octet(input [7:0] d);
    reg r;
    begin
      @(negedge i_clock);
      i_sym_valid = 1'b1;
      i_sym_data = d;
      r = 1'b0;
      while (!r) begin
        #1 r = o_sym_ready;
        @(posedge i_clock);
        if (!r) @(negedge i_clock);
      end
    end
  endtask
  task rx_frame(input [13:0] len, input [7:0] flags, input bad);
    reg [7:0] h[0:17];
    reg [15:0] c;
    reg [7:0] err;
    reg [31:0] f;
    integer i;
    begin
      c = `PRFC_HCS_INIT;
      for (i = 0; i < 16; i = i + 1) begin
        h[i] = (i == 0) ? len[7:0] : (i == 1) ? {2'b00, len[13:8]} :
          (i == 2) ? flags : 8'h30 + i[7:0];
        c = crc16(c, h[i]);
      end
      h[16] = c[15:8] ^ {7'h00, bad};
      h[17] = c[7:0];
      err = {7'h00, bad} << `PRFC_ERR_HCS;
      exp_q.delete();
      mac.got.delete();
      mac.falls = 0;
      wait_on(0);
      @(negedge i_clock);
      i_sync_found = 1'b1;
      @(negedge i_clock);
      i_sync_found = 1'b0;
      wait_on(1);
      // Reference pulse inside the active frame, where a latch may happen
      i_rng_ref = 1'b1;
      t_rng = $time;
      @(negedge i_clock);
      i_rng_ref = 1'b0;
      for (i = 0; i < 18; i = i + 1) begin
        send_octet(h[i]);
        exp_q.push_back(h[i]);
      end
      exp_q.push_back(err);
      f = 32'hffff_ffff;
      if (!bad && len != 0) begin
        for (i = 0; i < len; i = i + 1) begin
          f = fcs32(f, 8'ha0 + i[7:0]);
          send_octet(8'ha0 + i[7:0]);
          exp_q.push_back(8'ha0 + i[7:0]);
        end
        for (i = 0; i < `PRFC_FCS_LEN; i = i + 1) begin
          send_octet(f[31:24]);
          exp_q.push_back(f[31:24]);
          f = f << 8;
        end
      end
      @(negedge i_clock);
      i_sym_valid = 1'b0;
      i_sym_last = 1'b1;
      t_last = $time;
      @(negedge i_clock);
      i_sym_last = 1'b0;
      exp_q.push_back(SIGNAL_STRENGTH_OCTET);
      exp_q.push_back(LINK_QUALITY_OCTET);
      exp_q.push_back(err);
      wait_on(3);
      wait_on(2);
      check(mac.got.size(), exp_q.size());
      for (i = 0; i < exp_q.size(); i = i + 1)
        check(mac.got[i], exp_q[i]);
      // MAC side validates the payload against the delivered check octets
      if (!bad && len != 0) begin
        f = 32'hffff_ffff;
        for (i = 0; i < len; i = i + 1)
          f = fcs32(f, mac.got[`PRFC_HDR_LEN + 1 + i]);
        for (i = 0; i < `PRFC_FCS_LEN; i = i + 1) begin
          check(mac.got[`PRFC_HDR_LEN + 1 + len + i], f[31:24]);
          f = f << 8;
        end
      end
    end
  endtask
  task rx_start;
    @(negedge i_clock);
    i_rx_en = 1'b1;
    @(negedge i_clock);
    check(o_data_oe, 1);
    check(o_rx_path_on, 1);
    check(o_acq_antenna, 2'h1);
    check(o_acq_channel, 8'h09);
  endtask
  task rx_stop;
    check(o_data_oe, 1);
    @(negedge i_clock);
    i_rx_en = 1'b0;
    @(negedge i_clock);
    check(o_data_oe, 0);
    repeat (3) @(negedge i_clock);
  endtask
  task t_single;
    stall = 1'b1;
    rx_start;
    rx_frame(14'd3, 8'h00, 1'b0);
    check(mac.falls, 0);
    rx_stop;
    stall = 1'b0;
  endtask
  task t_hcs;
    i_preamble_type_select = 1'b1;
    rx_start;
    rx_frame(14'd2, 8'h00, 1'b1);
    wait_on(0);
    check(o_acq_burst_preamble, 1);
    rx_stop;
    i_preamble_type_select = 1'b0;
  endtask
  task t_zero;
    stall = 1'b1;
    rx_start;
    rx_frame(14'd0, 8'h00, 1'b0);
    rx_stop;
    stall = 1'b0;
  endtask
  task t_ddr;
    i_interface_config_register = 8'h02;
    rx_start;
    rx_frame(14'd5, 8'h00, 1'b0);
    check(mac.falls > 0, 1);
    rx_stop;
    i_interface_config_register = 8'h00;
  endtask
  task t_burst;
    i_preamble_follow_bit = 1'b1;
    i_ranging_enable_bit = 1'b1;
    rx_start;
    rx_frame(14'd1, 8'h03, 1'b0);
    ts0 = o_ranging_timestamp_register;
    tr0 = t_rng;
    wait_on(0);
    // Search starts MIF edges after the trailing-edge edge, seen one later
    waited = ($time - t_last) / 4;
    check(waited, MIF + 1);
    check(o_acq_burst_preamble, 1);
    rx_frame(14'd0, 8'h00, 1'b0);
    check(o_ranging_timestamp_register - ts0, (t_rng - tr0) / 4);
    repeat (MIF + 10) @(negedge i_clock);
    check(o_acq_enable, 0);
    rx_stop;
    i_preamble_follow_bit = 1'b0;
    i_ranging_enable_bit = 1'b0;
  endtask
  task t_tx;
    @(negedge i_clock);
    i_tx_en = 1'b1;
    @(negedge i_clock);
    check(o_tx_path_en, 1);
    check(o_activity_flag, 1);
    @(negedge i_clock);
    i_tx_en = 1'b0;
    #1 check(o_tx_path_en, 0);
    wait_on(2);
    check(waited <= FLU + 2, 1);
    rx_start;
    rx_stop;
  endtask
  initial begin
    repeat (16) @(negedge i_clock);
    i_resetn = 1'b1;
    t_single;
    t_hcs;
    t_zero;
    t_ddr;
    t_burst;
    t_tx;
    finish_test;
  end
  initial begin
    #60000;
    num_errors = num_errors + 1;
    finish_test;
  end
endmodule // prfc_rx_tb_top
